// ---- verilog/eus_pkg.sv ----
// package: register map, fields, reset values and types of the update block
package eus_pkg;
    // apb geometry: printed offsets are register indices, byte addr = 4*idx
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;
    localparam logic [7:0] IDX_CALIB = 8'h29;
    localparam logic [7:0] IDX_TSEL = 8'h40;
    localparam logic [7:0] IDX_TVAL = 8'h41;
    localparam logic [7:0] IDX_CTRL = 8'h50;
    localparam logic [7:0] IDX_STATUS = 8'h51;
    localparam logic [7:0] IDX_RTIMER = 8'h52;
    localparam logic [7:0] IDX_SRESET = 8'h53;
    localparam logic [7:0] IDX_UPDATE = 8'h54;
    localparam logic [7:0] IDX_UPSTAT = 8'h55;
    localparam logic [7:0] IDX_TUSED = 8'h56;

    // reset values
    localparam logic [7:0] CALIB_RST = 8'h33;
    localparam logic [7:0] TSEL_RST = 8'h00;
    localparam logic [7:0] TVAL_RST = 8'h18;
    localparam logic [7:0] RTIMER_RST = 8'h64;
    localparam logic [4:0] CTRL_RST = 5'h02;

    // control register fields
    localparam int CTRL_SLEEP = 0;
    localparam int CTRL_AUTO = 1;
    localparam int CTRL_DEPTH = 2;
    localparam int CTRL_ROT = 3;
    localparam int CTRL_INV = 4;
    localparam int CTRL_SCR_LSB = 5;
    localparam int TSEL_BIT = 0;
    localparam int SRESET_BIT = 0;
    localparam int UPD_START = 0;

    // status byte fields
    localparam int ST_SLEEP = 0;
    localparam int ST_SCR_LSB = 1;
    localparam int ST_AUTO = 3;
    localparam int ST_DEPTH = 4;

    // prescaler: slow clock edges per step = calib * 4096
    localparam int PRESC_SHIFT = 12;
    localparam int PRESC_W = 20;

    // complete image sizes in bytes (60 Kbytes, 120 Kbytes)
    localparam logic [16:0] BYTES_BIN = 17'h0f000;
    localparam logic [16:0] BYTES_GRAY = 17'h1e000;

    // 2-bit gray codes
    localparam logic [1:0] PIX_BLACK = 2'h0;
    localparam logic [1:0] PIX_DARK = 2'h1;
    localparam logic [1:0] PIX_LIGHT = 2'h2;
    localparam logic [1:0] PIX_WHITE = 2'h3;

    typedef enum logic [1:0] {
        SCR_NONE = 2'h0,
        SCR_LOADED = 2'h1,
        SCR_SHOWN = 2'h2,
        SCR_ABORTED = 2'h3
    } eus_screen_t;

    typedef enum logic [1:0] {
        UPD_IDLE = 2'h0,
        UPD_SCAN = 2'h1,
        UPD_DONE = 2'h3
    } eus_upd_state_t;

    // one image byte with the previous codes of the same pixels
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic [15:0] prev;
    } eus_pix_in_t;

    // expanded pixel codes, pixel 0 in the top pair
    typedef struct packed {
        logic valid;
        logic [3:0] count;
        logic [15:0] codes;
    } eus_pix_out_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic depth_bin;
        logic auto_refresh;
        eus_screen_t screen;
        logic sleep;
    } eus_status_t;
endpackage : eus_pkg

// ---- verilog/eus_update_status.sv ----
// update status, refresh timing, temperature override and pixel compare
`timescale 1ns/100ps
module eus_update_status
    import eus_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_external_reset_input_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // slow clock pin and temperature sensor reading
    input wire logic i_slow_clk,
    input wire logic [7:0] i_sensor_temp,
    // image byte stream for an update
    input wire eus_pix_in_t i_pix,
    output eus_pix_out_t o_pix,
    // results
    output logic [7:0] o_temp_used,
    output logic [7:0] o_status,
    output logic o_refresh_due,
    output logic o_fast_flow_update,
    output logic o_update_done,
    output logic o_rotate_portrait,
    output logic o_invert
);
    // reset sync stage plus soft reset pulse
    logic extn_s1_reg;
    logic extn_s2_reg;
    logic srst_reg;
    logic srst;
    // slow clock synchroniser and prescaler
    logic slow_s1_reg;
    logic slow_s2_reg;
    logic slow_d_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic step_tick;
    // registers
    logic [7:0] calib_reg;
    logic [7:0] tsel_reg;
    logic [7:0] tval_reg;
    logic [4:0] ctrl_reg;
    eus_screen_t screen_reg;
    logic [7:0] rtimer_reg;
    logic [7:0] temp_reg;
    eus_status_t status;
    // apb decode
    logic [7:0] idx;
    logic setup_ph;
    logic wr_acc;
    logic hit;
    logic [31:0] rd_mux;
    // update compare engine
    eus_upd_state_t upd_reg;
    logic [16:0] nbytes_reg;
    logic gray_reg;
    logic fast_reg;
    logic [15:0] codes;
    logic [3:0] cnt;
    logic [16:0] image_bytes;

    // expand a byte into 2-bit codes, first pixel in the top pair
    function automatic logic [15:0] expand(input logic [7:0] b,
                                           input logic gray);
        logic [15:0] r;
        r = 16'h0000;
        if (gray) begin
            r = {b, 8'h00};
        end else begin
            for (int i = 0; i < 8; i++) begin
                r[2*i +: 2] = b[i] ? PIX_WHITE : PIX_BLACK;
            end
        end
        return r;
    endfunction : expand

    // true when a pair code is dark or light gray
    function automatic logic is_gray(input logic [1:0] c);
        // only 01 and 10 are intermediate
        return (c == PIX_DARK) || (c == PIX_LIGHT);
    endfunction : is_gray

    // any changing pixel going to or from gray among the first n pairs
    function automatic logic gray_move(input logic [15:0] nw,
                                       input logic [15:0] pv,
                                       input logic [3:0] n);
        logic hitg;
        hitg = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if ((i < 8 - n) || (nw[2*i +: 2] == pv[2*i +: 2])) begin
                hitg = hitg;
            end else if (is_gray(nw[2*i +: 2]) || is_gray(pv[2*i +: 2])) begin
                hitg = 1'b1;
            end
        end
        return hitg;
    endfunction : gray_move

    // external reset pin is asynchronous to i_mclk: two flops first
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            extn_s1_reg <= 1'b0;
            extn_s2_reg <= 1'b0;
        end else begin
            extn_s1_reg <= i_external_reset_input_n;
            extn_s2_reg <= extn_s1_reg;
        end
    end

    // pin and soft command share one reset path; power-on uses the async i_rst
    assign srst = srst_reg || !extn_s2_reg;

    // apb decode; slave answers with zero wait states
    assign idx = i_paddr[IDX_LSB +: 8];
    assign setup_ph = i_psel && !i_penable;
    // writes to unmapped or misaligned addresses are dropped, not aliased
    assign wr_acc = i_psel && i_penable && i_pwrite && hit;
    assign o_pready = 1'b1;
    assign hit = (i_paddr[ADDR_W-1:IDX_LSB+8] == '0) &&
                 (i_paddr[IDX_LSB-1:0] == '0) &&
                 (idx == IDX_CALIB || idx == IDX_TSEL || idx == IDX_TVAL ||
                  idx == IDX_CTRL || idx == IDX_STATUS ||
                  idx == IDX_RTIMER || idx == IDX_SRESET ||
                  idx == IDX_UPDATE || idx == IDX_UPSTAT ||
                  idx == IDX_TUSED);

    // soft reset pulse, one cycle, from a write of bit 0
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            srst_reg <= 1'b0;
        end else begin
            srst_reg <= wr_acc && hit && idx == IDX_SRESET &&
                        i_pwdata[SRESET_BIT];
        end
    end

    // slow clock pin: two flops, edge detect only after the second
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            slow_s1_reg <= 1'b0;
            slow_s2_reg <= 1'b0;
            slow_d_reg <= 1'b0;
        end else begin
            slow_s1_reg <= i_slow_clk;
            slow_s2_reg <= slow_s1_reg;
            slow_d_reg <= slow_s2_reg;
        end
    end

    // count slow rising edges up to calib * 4096
    // calib of zero holds the tick off rather than firing every edge
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            presc_reg <= '0;
        end else if (srst) begin
            presc_reg <= '0;
        end else if (slow_s2_reg && !slow_d_reg) begin
            if (step_tick) begin
                presc_reg <= '0;
            end else begin
                presc_reg <= presc_reg + 1'b1;
            end
        end
    end
    assign step_tick = (calib_reg != 8'h00) &&
        (presc_reg == PRESC_W'(({12'h000, calib_reg} << PRESC_SHIFT) - 1));

    // configuration registers written over apb
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            calib_reg <= CALIB_RST;
            tsel_reg <= TSEL_RST;
            tval_reg <= TVAL_RST;
            ctrl_reg <= CTRL_RST;
            screen_reg <= SCR_NONE;
        end else if (srst) begin
            // normal, binary, portrait, positive, auto refresh
            calib_reg <= CALIB_RST;
            tsel_reg <= TSEL_RST;
            tval_reg <= TVAL_RST;
            ctrl_reg <= CTRL_RST;
            screen_reg <= SCR_NONE;
        end else if (wr_acc) begin
            case (idx)
                IDX_CALIB: begin
                    calib_reg <= i_pwdata[7:0];
                end
                IDX_TSEL: begin
                    tsel_reg <= i_pwdata[7:0];
                end
                IDX_TVAL: begin
                    tval_reg <= i_pwdata[7:0];
                end
                IDX_CTRL: begin
                    ctrl_reg <= i_pwdata[4:0];
                    screen_reg <= eus_screen_t'(i_pwdata[CTRL_SCR_LSB +: 2]);
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    // refresh timer: software load wins, otherwise step countdown
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rtimer_reg <= RTIMER_RST;
        end else if (srst) begin
            // ten minutes in 6 s steps
            rtimer_reg <= RTIMER_RST;
        end else if (wr_acc && idx == IDX_RTIMER) begin
            rtimer_reg <= i_pwdata[7:0];
        end else if (step_tick && slow_s2_reg && !slow_d_reg &&
                     ctrl_reg[CTRL_AUTO] && rtimer_reg != 8'h00) begin
            rtimer_reg <= rtimer_reg - 8'h01;
        end
    end
    assign o_refresh_due = (rtimer_reg == 8'h00);

    // override value replaces the sensor when selected
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            temp_reg <= 8'h00;
        end else begin
            temp_reg <= tsel_reg[TSEL_BIT] ? tval_reg : i_sensor_temp;
        end
    end
    assign o_temp_used = temp_reg;

    // status byte assembly
    always_comb begin
        status.sleep = ctrl_reg[CTRL_SLEEP];
        status.screen = screen_reg;
        status.auto_refresh = ctrl_reg[CTRL_AUTO];
        status.depth_bin = !ctrl_reg[CTRL_DEPTH];
        status.reserved = 3'h0;
    end
    // one byte, upper bus bits zero
    assign o_status = status;
    assign o_rotate_portrait = !ctrl_reg[CTRL_ROT];
    assign o_invert = ctrl_reg[CTRL_INV];

    // byte count of one complete image
    assign image_bytes = ctrl_reg[CTRL_DEPTH] ? BYTES_GRAY : BYTES_BIN;
    assign codes = expand(i_pix.data, ctrl_reg[CTRL_DEPTH]);
    assign cnt = ctrl_reg[CTRL_DEPTH] ? 4'h4 : 4'h8;

    // expanded pixel output registered for the memory side
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_pix <= '0;
        end else begin
            o_pix.valid <= i_pix.valid && upd_reg == UPD_SCAN;
            o_pix.codes <= codes;
            o_pix.count <= cnt;
        end
    end

    // image pointer kept outside
    // update compare: start, scan a whole image, then report
    // the pointer to image memory lives outside, so nothing to rebuild
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            upd_reg <= UPD_IDLE;
            nbytes_reg <= '0;
            gray_reg <= 1'b0;
            fast_reg <= 1'b0;
        end else if (srst) begin
            upd_reg <= UPD_IDLE;
            nbytes_reg <= '0;
            gray_reg <= 1'b0;
            fast_reg <= 1'b0;
        end else begin
            case (upd_reg)
                UPD_IDLE, UPD_DONE: begin
                    if (wr_acc && idx == IDX_UPDATE && i_pwdata[UPD_START]) begin
                        upd_reg <= UPD_SCAN;
                        nbytes_reg <= '0;
                        gray_reg <= 1'b0;
                    end
                end
                UPD_SCAN: begin
                    if (i_pix.valid) begin
                        // any gray transition forces slow waveform
                        if (gray_move(codes, i_pix.prev, cnt)) begin
                            gray_reg <= 1'b1;
                        end
                        nbytes_reg <= nbytes_reg + 17'h00001;
                        if (nbytes_reg == image_bytes - 17'h00001) begin
                            upd_reg <= UPD_DONE;
                            fast_reg <= !(gray_reg ||
                                gray_move(codes, i_pix.prev, cnt));
                        end
                    end
                end
                default: begin
                    upd_reg <= UPD_IDLE;
                end
            endcase
        end
    end
    assign o_fast_flow_update = fast_reg;
    assign o_update_done = (upd_reg == UPD_DONE);

    // read mux, captured in the setup phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            IDX_CALIB: rd_mux[7:0] = calib_reg;
            IDX_TSEL: rd_mux[7:0] = tsel_reg;
            IDX_TVAL: rd_mux[7:0] = tval_reg;
            IDX_CTRL: rd_mux[6:0] = {screen_reg, ctrl_reg};
            IDX_STATUS: rd_mux[7:0] = status;
            IDX_RTIMER: rd_mux[7:0] = rtimer_reg;
            IDX_UPSTAT: rd_mux[2:0] = {fast_reg, gray_reg,
                                       upd_reg == UPD_DONE};
            IDX_TUSED: rd_mux[7:0] = temp_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data and error registered so the access phase sees flops
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup_ph) begin
            o_prdata <= (hit && !i_pwrite) ? rd_mux : 32'h0000_0000;
            o_pslverr <= !hit;
        end
    end
endmodule : eus_update_status

// ---- dv/eus_update_status_asserts.sv ----
// checker: port-level properties of the update status block
`timescale 1ns/100ps
module eus_update_status_asserts
    import eus_pkg::*;
(
    // clock, reset and apb
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    // pixel stream and results
    input wire eus_pix_in_t i_pix,
    input wire eus_pix_out_t o_pix,
    input wire logic [7:0] o_status,
    input wire logic o_refresh_due,
    input wire logic o_rotate_portrait,
    input wire logic o_invert
);
    localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [11:0] A_TIM = {2'h0, IDX_RTIMER, 2'h0};
    logic wr;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // pready is always high, so psel and penable mark the taking edge
    assign wr = i_psel && i_penable && i_pwrite;

    // binary expansion: each bit becomes a black or white pair
    function automatic logic [15:0] bexp(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            bexp[2*i+:2] = {2{d[i]}};
        end
    endfunction : bexp

    a_status_reserved:
        assert property (o_status[7:5] == 3'h0)
            else $error("reserved status bits not zero");
    a_status_mode:
        assert property (wr && i_paddr == A_CTRL |=>
            o_status[0] == $past(i_pwdata[0]) &&
            o_status[3] == $past(i_pwdata[1]) &&
            o_status[4] == !$past(i_pwdata[2]))
            else $error("status mode bits do not follow control");
    a_screen_state:
        assert property (wr && i_paddr == A_CTRL |=>
            o_status[2:1] == $past(i_pwdata[6:5]))
            else $error("screen state does not follow control");
    a_status_byte:
        assert property (i_psel && i_penable && !i_pwrite &&
            i_paddr == A_STAT |-> o_prdata == {24'h0, o_status})
            else $error("status read is not the one status byte");
    a_pix_binary:
        assert property (o_pix.valid && o_pix.count == 4'h8 |->
            $past(i_pix.valid) && o_pix.codes == bexp($past(i_pix.data)))
            else $error("binary byte expanded wrongly");
    a_pix_gray:
        assert property (o_pix.valid && o_pix.count == 4'h4 |->
            o_pix.codes == {$past(i_pix.data), 8'h00})
            else $error("gray byte expanded wrongly");
    a_pix_depth:
        assert property (o_pix.valid |-> (o_pix.count == 4'h8) == o_status[4])
            else $error("pixel count disagrees with depth");
    a_timer_write:
        assert property (wr && i_paddr == A_TIM |=>
            o_refresh_due == ($past(i_pwdata[7:0]) == 8'h00))
            else $error("refresh due wrong after timer write");
    a_reset_values:
        assert property ($fell(i_rst) |-> o_status == 8'h18 &&
            !o_refresh_due && o_rotate_portrait && !o_invert)
            else $error("reset defaults wrong");
endmodule : eus_update_status_asserts

// ---- dv/eus_host_model.sv ----
// host model: apb master and image byte source
`timescale 1ns/100ps
module eus_host_model
    import eus_pkg::*;
(
    // clock and apb answer
    input wire logic i_mclk,
    input wire logic i_pready,
    // apb request
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [ADDR_W-1:0] o_paddr,
    output logic [31:0] o_pwdata,
    // image byte stream
    output eus_pix_in_t o_pix
);
    logic [19:0] pq[$];
    int seed = 32'h8140;

    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = '0;
        o_pwdata = '0;
        o_pix = '0;
    end

    // one transfer; address and data are scrambled once released
    task automatic xfer(input logic [ADDR_W-1:0] a, input logic w,
                        input logic [31:0] d);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_mclk);
        o_penable <= 1'b1;
        @(posedge i_mclk);
        while (!i_pready) @(posedge i_mclk);
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
        o_pwdata <= ~d;
        @(posedge i_mclk);
    endtask : xfer

    // byte burst; binary previous codes are black or white only
    task automatic burst(input int n, input logic gray);
        logic [7:0] d;
        logic [7:0] p;
        logic [15:0] e;
        logic [15:0] pv;
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            p = 8'($random(seed));
            for (int i = 0; i < 8; i++) begin
                e[2*i+:2] = {2{d[i]}};
                pv[2*i+:2] = {2{p[i]}};
            end
            if (gray) begin
                e = {d, 8'h00};
                pv = {p, 8'h00};
            end
            pq.push_back({gray ? 4'h4 : 4'h8, e});
            o_pix <= '{1'b1, d, pv};
            @(posedge i_mclk);
        end
        o_pix <= '{1'b0, ~d, ~pv};
    endtask : burst
endmodule : eus_host_model

// ---- dv/tb_top.sv ----
// testbench top: register, timer, temperature and pixel scenarios
`timescale 1ns/100ps
module tb_top
    import eus_pkg::*;
;
    logic i_mclk, i_rst, i_external_reset_input_n, i_slow_clk;
    logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [ADDR_W-1:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic [7:0] i_sensor_temp, o_temp_used, o_status;
    eus_pix_in_t i_pix;
    eus_pix_out_t o_pix;
    logic o_refresh_due, o_fast_flow_update, o_update_done;
    logic o_rotate_portrait, o_invert;
    int failures = 0;
    int n_checks = 0;
    int seed = 32'h8140;
    logic [32:0] rq[$];

    eus_update_status eus_update_status_inst (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_external_reset_input_n(i_external_reset_input_n),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_slow_clk(i_slow_clk),
        .i_sensor_temp(i_sensor_temp), .i_pix(i_pix), .o_pix(o_pix),
        .o_temp_used(o_temp_used), .o_status(o_status),
        .o_refresh_due(o_refresh_due), .o_fast_flow_update(o_fast_flow_update),
        .o_update_done(o_update_done), .o_rotate_portrait(o_rotate_portrait),
        .o_invert(o_invert));

    eus_host_model eus_host_model_inst (.i_mclk(i_mclk), .i_pready(o_pready),
        .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
        .o_paddr(i_paddr), .o_pwdata(i_pwdata), .o_pix(i_pix));

    task automatic rd(input logic [7:0] idx, input logic [32:0] e);
        rq.push_back(e);
        eus_host_model_inst.xfer({2'h0, idx, 2'h0}, 1'b0, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        eus_host_model_inst.xfer({2'h0, idx, 2'h0}, 1'b1, d);
    endtask : wr

    // slow clock pulses, two master cycles high and two low
    task automatic slow(input int n);
        repeat (n) begin
            i_slow_clk <= 1'b1;
            repeat (2) @(posedge i_mclk);
            i_slow_clk <= 1'b0;
            repeat (2) @(posedge i_mclk);
        end
    endtask : slow

    task automatic chk_rd(input logic [32:0] got, input logic [32:0] e);
        n_checks++;
        if (got !== e) begin
            failures++;
            $display("[FAIL] %0t read %h expected %h", $time, got, e);
        end
    endtask : chk_rd

    task automatic chk_pix(input logic [19:0] got, input logic [19:0] e);
        n_checks++;
        if (got !== e) begin
            failures++;
            $display("[FAIL] %0t pixels %h expected %h", $time, got, e);
        end
    endtask : chk_pix

    task automatic results();
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // clock: 20 ns period
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // monitor: oldest note against each read answer and pixel word
    always @(posedge i_mclk) begin
        if (i_psel && i_penable && o_pready && !i_pwrite) begin
            chk_rd({o_pslverr, o_prdata}, rq.pop_front());
        end
        if (o_pix.valid) begin
            chk_pix({o_pix.count, o_pix.codes},
                eus_host_model_inst.pq.pop_front());
        end
    end

    // watchdog: the run needs about 62k cycles
    initial begin
        repeat (90000) @(posedge i_mclk);
        failures++;
        results();
    end

    // main sequence
    initial begin
        logic [7:0] v;
        logic [7:0] t;
        i_rst = 1'b1;
        i_external_reset_input_n = 1'b1;
        i_slow_clk = 1'b0;
        i_sensor_temp = 8'h00;
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_mclk);
        wr(IDX_CALIB, 32'h1);
        rd(IDX_CALIB, 33'h1);
        wr(IDX_RTIMER, 32'h2);
        wr(IDX_UPDATE, 32'h1);
        fork
            begin
                slow(4096);
                rd(IDX_RTIMER, 33'h1);
                slow(4096);
                rd(IDX_RTIMER, 33'h0);
                slow(4096);
                rd(IDX_RTIMER, 33'h0);
            end
            begin
                eus_host_model_inst.burst(61439, 1'b0);
                chk_rd({31'h0, o_update_done, o_fast_flow_update},
                    33'h0);
                rd(IDX_UPSTAT, 33'h0);
                eus_host_model_inst.burst(1, 1'b0);
                repeat (3) @(posedge i_mclk);
                chk_rd({31'h0, o_update_done, o_fast_flow_update},
                    33'h3);
                rd(IDX_UPSTAT, 33'h5);
            end
        join
        repeat (8) begin
            v = 8'($random(seed));
            wr(IDX_CTRL, {25'h0, v[6:0]});
            rd(IDX_STATUS, {28'h0, ~v[2], v[1], v[6:5], v[0]});
        end
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            t = 8'($random(seed));
            i_sensor_temp <= t;
            wr(IDX_TVAL, {24'h0, v});
            wr(IDX_TSEL, 32'(i));
            rd(IDX_TUSED, {25'h0, i[0] ? v : t});
            chk_rd({25'h0, o_temp_used}, {25'h0, i[0] ? v : t});
        end
        wr(IDX_CTRL, 32'h6);
        wr(IDX_UPDATE, 32'h1);
        eus_host_model_inst.burst(6, 1'b1);
        wr(IDX_SRESET, 32'h1);
        repeat (3) @(posedge i_mclk);
        rd(IDX_CTRL, 33'h2);
        rd(IDX_CALIB, 33'h33);
        rd(IDX_RTIMER, 33'h64);
        wr(IDX_STATUS, 32'hff);
        rd(IDX_STATUS, 33'h18);
        wr(IDX_TVAL, 32'h55);
        i_external_reset_input_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_external_reset_input_n <= 1'b1;
        repeat (6) @(posedge i_mclk);
        rd(IDX_TVAL, 33'h18);
        rd(8'h57, 33'h100000000);
        repeat (4) @(posedge i_mclk);
        results();
    end
endmodule : tb_top

bind eus_update_status eus_update_status_asserts eus_update_status_asserts_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .i_pix(i_pix), .o_pix(o_pix), .o_status(o_status),
    .o_refresh_due(o_refresh_due), .o_rotate_portrait(o_rotate_portrait),
    .o_invert(o_invert));
